/* File: rtl/sfps_top.sv */
// Slave FIFO port: four FIFOs reached by an external bus master.
// Assumes the master keeps its timing; SYS_CLK runs free.
//
// Notes on behaviour
// - Clocked output enable drives prefetched word, no advance
// - Read needs select and read strobe together
// - Clocked read: advance pointer, then present word
// - Bus driven only while output enable asserted
// - Clocked burst read: next word every edge
// - Clocked write: store, advance, flags afterward
// - Clocked burst write: one word every edge
// - Clocked commit with last word includes that word
// - Auto mode commits at programmed length
// - Strobe mode: enable alone shows old word
// - Strobe read: present word, then advance
// - Strobe write: store on strobe release
`timescale 1ns/10ps
`include "sfps_params.svh"
module sfps_top (
  input  wire logic                SYS_CLK,
  input  wire logic                ARST_N,
  input  wire logic                INTERFACE_CLOCK,
  input  wire logic                FIFO_CHIP_SELECT_N,
  input  wire logic                FIFO_OUTPUT_ENABLE_N,
  input  wire logic                FIFO_READ_STROBE_N,
  input  wire logic                FIFO_WRITE_STROBE_N,
  input  wire logic                PACKET_COMMIT_STROBE_N,
  input  wire sfps_pkg::sfps_sel_t FIFO_SELECT_ADDR,
  input  wire sfps_pkg::sfps_word_t FIFO_DATA_I,
  output sfps_pkg::sfps_word_t     FIFO_DATA_O,
  output logic                     FIFO_DATA_OE,
  output logic                     FIFO_FULL_N,
  output logic                     FIFO_EMPTY_N,
  input  wire logic                ASYNC_MODE,
  input  wire logic                AUTO_MODE,
  input  wire sfps_pkg::sfps_len_t AUTO_PACKET_LENGTH,
  output logic                     IN_VALID,
  input  wire logic                IN_READY,
  output sfps_pkg::sfps_word_t     IN_DATA,
  output sfps_pkg::sfps_sel_t      IN_SEL,
  output logic                     IN_LAST,
  input  wire logic                FILL_VALID,
  output logic                     FILL_READY,
  input  wire sfps_pkg::sfps_word_t FILL_DATA,
  input  wire logic                FILL_SEL
);
  import sfps_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic f_empty(sfps_ptr_t w, sfps_ptr_t r);
    return w == r;
  endfunction

  function automatic logic f_full(sfps_ptr_t w, sfps_ptr_t r);
    return (w ^ r) == sfps_ptr_t'(`SFPS_DEPTH);
  endfunction

  function automatic sfps_ptr_t f_inc(sfps_ptr_t p, logic en);
    return p + sfps_ptr_t'(en);
  endfunction

  function automatic logic [`SFPS_AW-1:0] f_idx(sfps_ptr_t p);
    return p[`SFPS_AW-1:0];
  endfunction

  // ==========================================
  // Reset release
  logic s_rst_m_q;
  logic s_rst_n_q;
  logic l_rst_m_q;
  logic l_rst_n_q;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_rst_m_q <= 1'b0;
      s_rst_n_q <= 1'b0;
    end else begin
      s_rst_m_q <= 1'b1;
      s_rst_n_q <= s_rst_m_q;
    end
  end

  always_ff @(posedge INTERFACE_CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      l_rst_m_q <= 1'b0;
      l_rst_n_q <= 1'b0;
    end else begin
      l_rst_m_q <= 1'b1;
      l_rst_n_q <= l_rst_m_q;
    end
  end

  // ==========================================
  // Pin capture
  sfps_pins_t pin_raw;
  sfps_pins_t pin_m_q;
  sfps_pins_t pin_s_q;
  sfps_pins_t pin_p_q;
  sfps_pins_t bus;
  sfps_cfg_t  cfg_m_q;
  sfps_cfg_t  cfg;

  assign pin_raw = '{cs:   ~FIFO_CHIP_SELECT_N,
                     oe:   ~FIFO_OUTPUT_ENABLE_N,
                     rd:   ~FIFO_READ_STROBE_N,
                     wr:   ~FIFO_WRITE_STROBE_N,
                     pe:   ~PACKET_COMMIT_STROBE_N,
                     addr: FIFO_SELECT_ADDR,
                     data: FIFO_DATA_I};

  always_ff @(posedge INTERFACE_CLOCK or negedge l_rst_n_q) begin
    if (!l_rst_n_q) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
      cfg_m_q <= '0;
      cfg     <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      cfg_m_q <= '{async_mode: ASYNC_MODE,
                   auto_mode:  AUTO_MODE,
                   len:        AUTO_PACKET_LENGTH};
      cfg     <= cfg_m_q;
    end
  end

  // Strobe mode sees the pins through the synchroniser
  assign bus = cfg.async_mode ? pin_p_q : pin_raw;

  // ==========================================
  // Strobe events
  logic rd_ev;
  logic wr_ev;
  logic pe_ev;

  always_comb begin
    if (cfg.async_mode) begin
      rd_ev = pin_s_q.cs && pin_s_q.rd && !pin_p_q.rd;
      wr_ev = pin_p_q.cs && pin_p_q.wr && !pin_s_q.wr;
      pe_ev = pin_s_q.cs && pin_s_q.pe && !pin_p_q.pe;
    end else begin
      rd_ev = pin_raw.cs && pin_raw.rd;
      wr_ev = pin_raw.cs && pin_raw.wr;
      pe_ev = pin_raw.cs && pin_raw.pe;
    end
  end

  // ==========================================
  // FIFO state
  sfps_word_t mem_q     [`SFPS_NFIFO][`SFPS_DEPTH];
  logic       last_q    [`SFPS_NFIFO][`SFPS_DEPTH];
  sfps_ptr_t  wr_ptr_q  [`SFPS_NFIFO];
  sfps_ptr_t  rd_ptr_q  [`SFPS_NFIFO];
  sfps_ptr_t  cmt_ptr_q [`SFPS_NFIFO];

  sfps_sel_t             sel;
  logic                  sel_in;
  logic                  m_rd;
  logic                  m_wr;
  logic                  pe_ok;
  logic                  auto_ok;
  logic                  commit;
  sfps_ptr_t             wr_ptr_d;
  sfps_ptr_t             pend_d;
  sfps_ptr_t             rd_sel_ptr;
  logic [`SFPS_AW-1:0]   rd_idx;
  logic [`SFPS_AW-1:0]   wr_idx;
  logic                  sel_empty;
  logic                  sel_full;
  sfps_sel_t             fsel;
  logic                  fill_take;
  sfps_sel_t             dsel;
  logic                  drain_pop;

  sfps_stream_if #(.W(`SFPS_XW)) drain_l ();
  sfps_stream_if #(.W(`SFPS_XW)) drain_s ();
  sfps_stream_if #(.W(`SFPS_XW)) in_s ();
  sfps_stream_if #(.W(`SFPS_FW)) fill_s ();
  sfps_stream_if #(.W(`SFPS_FW)) fill_l ();

  assign sel        = bus.addr;
  assign sel_in     = sel[`SFPS_DIR_BIT];
  assign rd_sel_ptr = rd_ptr_q[sel];
  assign rd_idx     = f_idx(rd_sel_ptr);
  assign wr_idx     = f_idx(wr_ptr_q[sel]);
  assign sel_empty  = f_empty(wr_ptr_q[sel], rd_sel_ptr);
  assign sel_full   = f_full(wr_ptr_q[sel], rd_sel_ptr);

  // Master writes go to host-bound FIFOs, reads come from the others
  assign m_wr     = wr_ev && sel_in && !sel_full;
  assign m_rd     = rd_ev && !sel_in && !sel_empty;
  assign wr_ptr_d = f_inc(wr_ptr_q[sel], m_wr);
  assign pend_d   = wr_ptr_d - cmt_ptr_q[sel];
  assign pe_ok    = pe_ev && sel_in && pend_d != '0;
  assign auto_ok  = cfg.auto_mode && sel_in && cfg.len != '0 &&
                    pend_d >= sfps_ptr_t'(cfg.len);
  assign commit   = pe_ok || auto_ok;

  // Fill stream from the system side
  assign fsel           = {1'b0, fill_l.data[`SFPS_DW]};
  assign fill_l.ready   = !f_full(wr_ptr_q[fsel], rd_ptr_q[fsel]);
  assign fill_take      = fill_l.valid && fill_l.ready;

  // Drain committed words toward the system side
  assign dsel = (rd_ptr_q[`SFPS_IN_A] != cmt_ptr_q[`SFPS_IN_A]) ?
                sfps_sel_t'(`SFPS_IN_A) : sfps_sel_t'(`SFPS_IN_B);
  assign drain_l.valid = rd_ptr_q[dsel] != cmt_ptr_q[dsel];
  assign drain_l.data  = {dsel, last_q[dsel][f_idx(rd_ptr_q[dsel])],
                          mem_q[dsel][f_idx(rd_ptr_q[dsel])]};
  assign drain_pop     = drain_l.valid && drain_l.ready;

  always_ff @(posedge INTERFACE_CLOCK) begin
    if (m_wr) begin
      mem_q[sel][wr_idx] <= bus.data;
    end
    if (fill_take) begin
      mem_q[fsel][f_idx(wr_ptr_q[fsel])] <= fill_l.data[`SFPS_DW-1:0];
    end
    if (m_wr || commit) begin
      last_q[sel][f_idx(sfps_ptr_t'(wr_ptr_d - 1'b1))] <= commit;
    end
  end

  always_ff @(posedge INTERFACE_CLOCK or negedge l_rst_n_q) begin
    if (!l_rst_n_q) begin
      for (int f = 0; f < `SFPS_NFIFO; f++) begin
        wr_ptr_q[f]  <= '0;
        rd_ptr_q[f]  <= '0;
        cmt_ptr_q[f] <= '0;
      end
    end else begin
      for (int f = 0; f < `SFPS_NFIFO; f++) begin
        wr_ptr_q[f] <= f_inc(wr_ptr_q[f],
          (m_wr && sel == sfps_sel_t'(f)) ||
          (fill_take && fsel == sfps_sel_t'(f)));
        rd_ptr_q[f] <= f_inc(rd_ptr_q[f],
          (m_rd && sel == sfps_sel_t'(f)) ||
          (drain_pop && dsel == sfps_sel_t'(f)));
        if (commit && sel == sfps_sel_t'(f)) begin
          cmt_ptr_q[f] <= wr_ptr_d;
        end
      end
    end
  end

  // ==========================================
  // Data bus and flags
  always_ff @(posedge INTERFACE_CLOCK or negedge l_rst_n_q) begin
    if (!l_rst_n_q) begin
      FIFO_DATA_O <= '0;
    end else if (!cfg.async_mode) begin
      FIFO_DATA_O <= mem_q[sel][f_idx(f_inc(rd_sel_ptr, m_rd))];
    end else if (m_rd) begin
      FIFO_DATA_O <= mem_q[sel][rd_idx];
    end
  end

  always_ff @(posedge INTERFACE_CLOCK or negedge l_rst_n_q) begin
    if (!l_rst_n_q) begin
      FIFO_DATA_OE <= 1'b0;
      FIFO_FULL_N  <= 1'b1;
      FIFO_EMPTY_N <= 1'b0;
    end else begin
      FIFO_DATA_OE <= bus.cs && bus.oe;
      FIFO_FULL_N  <= !sel_full;
      FIFO_EMPTY_N <= !sel_empty;
    end
  end

  // ==========================================
  // Domain crossings and system ports
  sfps_word_sync #(.W(`SFPS_XW)) u_drain_sync (
    .src_clk   (INTERFACE_CLOCK),
    .src_rst_n (l_rst_n_q),
    .dst_clk   (SYS_CLK),
    .dst_rst_n (s_rst_n_q),
    .s_in      (drain_l),
    .s_out     (drain_s)
  );

  sfps_pair_buf #(.W(`SFPS_XW)) u_in_buf (
    .clk   (SYS_CLK),
    .rst_n (s_rst_n_q),
    .s_in  (drain_s),
    .s_out (in_s)
  );

  sfps_word_sync #(.W(`SFPS_FW)) u_fill_sync (
    .src_clk   (SYS_CLK),
    .src_rst_n (s_rst_n_q),
    .dst_clk   (INTERFACE_CLOCK),
    .dst_rst_n (l_rst_n_q),
    .s_in      (fill_s),
    .s_out     (fill_l)
  );

  assign IN_VALID                  = in_s.valid;
  assign in_s.ready                = IN_READY;
  assign {IN_SEL, IN_LAST, IN_DATA} = in_s.data;
  assign fill_s.valid              = FILL_VALID;
  assign fill_s.data               = {FILL_SEL, FILL_DATA};
  assign FILL_READY                = fill_s.ready;

  // ==========================================
  // Checks
  default clocking cb @(posedge INTERFACE_CLOCK);
  endclocking
  default disable iff (!l_rst_n_q);

  rd_ptr_step_a: assert property (
    m_rd |=> rd_ptr_q[$past(sel)] == $past(rd_sel_ptr) + 1'b1)
    else $error("read pointer did not advance on a read");

  wr_store_a: assert property (
    m_wr |=> mem_q[$past(sel)][$past(wr_idx)] == $past(bus.data))
    else $error("written word not stored");

  cs_gate_a: assert property (
    !cfg.async_mode && !pin_raw.cs |-> !m_rd && !m_wr && !pe_ok)
    else $error("access taken without chip select");

  oe_drive_a: assert property (
    ##1 FIFO_DATA_OE == $past(bus.cs && bus.oe))
    else $error("bus drive does not follow output enable");

  sync_prefetch_a: assert property (
    !cfg.async_mode && !m_rd && !sel_empty |=>
      FIFO_DATA_O == $past(mem_q[sel][rd_idx]))
    else $error("prefetched word not presented");

  async_hold_a: assert property (
    cfg.async_mode && !m_rd |=> $stable(FIFO_DATA_O))
    else $error("strobe mode word changed without a read");

  async_read_a: assert property (
    cfg.async_mode && m_rd |=>
      FIFO_DATA_O == $past(mem_q[sel][rd_idx]) &&
      rd_ptr_q[$past(sel)] == $past(rd_sel_ptr) + 1'b1)
    else $error("strobe read word or pointer wrong");

  commit_incl_a: assert property (
    commit |=> cmt_ptr_q[$past(sel)] == $past(wr_ptr_d))
    else $error("commit boundary misses the last word");

  auto_len_a: assert property (
    cfg.auto_mode && cfg.len != '0 && sel_in |=>
      sfps_ptr_t'(wr_ptr_q[$past(sel)] - cmt_ptr_q[$past(sel)]) <
      sfps_ptr_t'($past(cfg.len)))
    else $error("auto commit missed at programmed length");

  async_wr_edge_a: assert property (
    cfg.async_mode && m_wr |-> pin_p_q.wr && !pin_s_q.wr)
    else $error("strobe write taken off the releasing edge");

  flag_sel_a: assert property (
    ##1 FIFO_EMPTY_N == !$past(sel_empty))
    else $error("empty flag does not track selected FIFO");

  burst_read_c: cover property (m_rd ##1 m_rd ##1 m_rd);
  burst_commit_c: cover property (m_wr ##1 m_wr ##1 (m_wr && pe_ok));
  auto_then_short_c: cover property (auto_ok ##[1:4] pe_ok);
  async_read_c: cover property (cfg.async_mode && m_rd);
endmodule

/* File: rtl/sfps_params.svh */
// Constants of the slave FIFO port sequencer.
// Assumes inclusion by bare name from rtl/.
`ifndef SFPS_PARAMS_SVH
`define SFPS_PARAMS_SVH
`define SFPS_DW      8
`define SFPS_AW      4
`define SFPS_DEPTH   16
`define SFPS_NFIFO   4
`define SFPS_SW      2
`define SFPS_LEN_W   5
`define SFPS_DIR_BIT 1
`define SFPS_IN_A    2
`define SFPS_IN_B    3
`define SFPS_XW      11
`define SFPS_FW      9
`define SFPS_BUF_N   2
`endif

/* File: rtl/sfps_pkg.sv */
// Types of the slave FIFO port sequencer.
// Assumes sfps_params.svh sits beside it.
`include "sfps_params.svh"
package sfps_pkg;
  typedef logic [`SFPS_DW-1:0]    sfps_word_t;
  typedef logic [`SFPS_AW:0]      sfps_ptr_t;
  typedef logic [`SFPS_SW-1:0]    sfps_sel_t;
  typedef logic [`SFPS_LEN_W-1:0] sfps_len_t;
  // Pin bundle, all strobes active high here
  typedef struct packed {
    logic       cs;
    logic       oe;
    logic       rd;
    logic       wr;
    logic       pe;
    sfps_sel_t  addr;
    sfps_word_t data;
  } sfps_pins_t;
  typedef struct packed {
    logic      async_mode;
    logic      auto_mode;
    sfps_len_t len;
  } sfps_cfg_t;
endpackage

/* File: rtl/sfps_stream_if.sv */
// Valid/ready word stream between the block's own modules.
// Assumes both ends share the clock named by the module using it.
`timescale 1ns/10ps
interface sfps_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/sfps_word_sync.sv */
// Toggle handshake carrying one word between two clock domains.
// Assumes each reset is released in its own domain.
`timescale 1ns/10ps
module sfps_word_sync #(parameter int W = 8) (
  input  wire logic     src_clk,
  input  wire logic     src_rst_n,
  input  wire logic     dst_clk,
  input  wire logic     dst_rst_n,
  sfps_stream_if.snk    s_in,
  sfps_stream_if.src    s_out
);
  logic         req_q;
  logic         busy_q;
  logic [W-1:0] hold_q;
  logic         ack_m_q;
  logic         ack_s_q;
  logic         req_m_q;
  logic         req_s_q;
  logic         seen_q;

  // ==========================================
  // Source side
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      req_q  <= 1'b0;
      busy_q <= 1'b0;
      hold_q <= '0;
    end else if (s_in.valid && !busy_q) begin
      req_q  <= ~req_q;
      busy_q <= 1'b1;
      hold_q <= s_in.data;
    end else if (busy_q && ack_s_q == req_q) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= seen_q;
      ack_s_q <= ack_m_q;
    end
  end

  assign s_in.ready = !busy_q;

  // ==========================================
  // Destination side
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
    end else begin
      req_m_q <= req_q;
      req_s_q <= req_m_q;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      seen_q <= 1'b0;
    end else if (s_out.valid && s_out.ready) begin
      seen_q <= req_s_q;
    end
  end

  assign s_out.valid = req_s_q ^ seen_q;
  assign s_out.data  = hold_q;
endmodule

/* File: rtl/sfps_pair_buf.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock for both sides.
`timescale 1ns/10ps
`include "sfps_params.svh"
module sfps_pair_buf #(parameter int W = 8) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  sfps_stream_if.snk    s_in,
  sfps_stream_if.src    s_out
);
  logic [W-1:0] mem_q [`SFPS_BUF_N];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign s_in.ready  = cnt_q != 2'(`SFPS_BUF_N);
  assign s_out.valid = cnt_q != 2'h0;
  assign s_out.data  = mem_q[rp_q];
  assign push        = s_in.valid && s_in.ready;
  assign pop         = s_out.valid && s_out.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= s_in.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q  <= wp_q ^ push;
      rp_q  <= rp_q ^ pop;
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule

/* File: verification/sfps_master_model.sv */
// Bus master model driving the slave FIFO port pins, strobes active low.
// Assumes the bench supplies the link clock and calls its tasks in turn.
`timescale 1ns/10ps
module sfps_master_model (
  input  wire logic          clk,
  output logic               cs_n,
  output logic               oe_n,
  output logic               rd_n,
  output logic               wr_n,
  output logic               pe_n,
  output sfps_pkg::sfps_sel_t  addr,
  output sfps_pkg::sfps_word_t data
);
  import sfps_pkg::*;
  initial begin
    cs_n = 1'h1;
    oe_n = 1'h1;
    rd_n = 1'h1;
    wr_n = 1'h1;
    pe_n = 1'h1;
    addr = 2'h0;
    data = 8'h00;
  end
  // ==========================================================
  // Clocked mode
  // Address and select a full cycle ahead of any strobe
  task automatic sel(input sfps_sel_t a);
    @(posedge clk);
    cs_n <= 1'h0;
    addr <= a;
    @(posedge clk);
  endtask
  task automatic desel();
    @(posedge clk);
    cs_n <= 1'h1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic oe(input logic v);
    @(posedge clk);
    oe_n <= !v;
  endtask
  // One word an edge, commit optional on the last word
  task automatic wr(input sfps_word_t w0, input int n, input logic pe);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wr_n <= 1'h0;
      data <= w0 + 8'(i);
      pe_n <= !(pe && i == n - 1);
    end
    @(posedge clk);
    wr_n <= 1'h1;
    pe_n <= 1'h1;
    data <= ~data;
  endtask
  task automatic rd(input int n);
    @(posedge clk);
    rd_n <= 1'h0;
    repeat (n) @(posedge clk);
    rd_n <= 1'h1;
  endtask
  task automatic commit();
    @(posedge clk);
    pe_n <= 1'h0;
    @(posedge clk);
    pe_n <= 1'h1;
  endtask
  // ==========================================================
  // Strobe mode: k 0 read with enable tied, 1 write, 2 commit
  task automatic apulse(input int k, input sfps_word_t w);
    @(posedge clk);
    data <= w;
    if (k == 0) begin
      rd_n <= 1'h0;
      oe_n <= 1'h0;
    end else if (k == 1) begin
      wr_n <= 1'h0;
    end else begin
      pe_n <= 1'h0;
    end
    repeat (5) @(posedge clk);
    rd_n <= 1'h1;
    oe_n <= 1'h1;
    wr_n <= 1'h1;
    pe_n <= 1'h1;
    repeat (4) @(posedge clk);
    data <= ~w;
  endtask
endmodule

/* File: verification/slave_fifo_port_sequencer_tb.sv */
// Self-checking bench for the slave FIFO port sequencer.
// Assumes the rtl files and the master model are compiled first.
`timescale 1ns/10ps
`define SFPS_CHK(n, e, g) chk(n, 16'(e), 16'(g))
module slave_fifo_port_sequencer_tb;
  import sfps_pkg::*;
  logic       sys_clk = 1'h0;
  logic       link_clk = 1'h1;
  logic       arst_n;
  logic       async_mode;
  logic       auto_mode;
  sfps_len_t  auto_len;
  logic       in_ready;
  logic       fill_valid;
  logic       fill_sel;
  sfps_word_t fill_data;
  sfps_word_t bus, data_o, in_data, m_data;
  sfps_sel_t  in_sel, m_addr;
  logic       data_oe, full_n, empty_n, in_valid, in_last, fill_ready;
  logic       cs_n, oe_n, rd_n, wr_n, pe_n;
  int         mismatches = 0;
  int         total_checks = 0;

  always #12.5 sys_clk = ~sys_clk;
  always #80 link_clk = ~link_clk;
  assign bus = data_oe ? data_o : m_data;

  sfps_master_model m (.clk(link_clk), .cs_n(cs_n), .oe_n(oe_n),
    .rd_n(rd_n), .wr_n(wr_n), .pe_n(pe_n), .addr(m_addr), .data(m_data));

  sfps_top dut (.SYS_CLK(sys_clk), .ARST_N(arst_n),
    .INTERFACE_CLOCK(link_clk), .FIFO_CHIP_SELECT_N(cs_n),
    .FIFO_OUTPUT_ENABLE_N(oe_n), .FIFO_READ_STROBE_N(rd_n),
    .FIFO_WRITE_STROBE_N(wr_n), .PACKET_COMMIT_STROBE_N(pe_n),
    .FIFO_SELECT_ADDR(m_addr), .FIFO_DATA_I(bus), .FIFO_DATA_O(data_o),
    .FIFO_DATA_OE(data_oe), .FIFO_FULL_N(full_n), .FIFO_EMPTY_N(empty_n),
    .ASYNC_MODE(async_mode), .AUTO_MODE(auto_mode),
    .AUTO_PACKET_LENGTH(auto_len), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_DATA(in_data), .IN_SEL(in_sel),
    .IN_LAST(in_last), .FILL_VALID(fill_valid), .FILL_READY(fill_ready),
    .FILL_DATA(fill_data), .FILL_SEL(fill_sel));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic lk(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic fill(input logic s, input sfps_word_t w0, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      fill_valid <= 1'h1;
      fill_sel <= s;
      fill_data <= w0 + 8'(i);
      #1;
      while (fill_ready !== 1'h1) begin
        @(posedge sys_clk);
        #1;
      end
      @(posedge sys_clk);
      fill_valid <= 1'h0;
    end
  endtask
  // Words stay stalled until this is called
  task automatic drain(input sfps_sel_t s, input sfps_word_t w0,
                       input int n);
    @(posedge sys_clk);
    in_ready <= 1'h1;
    for (int i = 0; i < n; i++) begin
      #1;
      while (in_valid !== 1'h1) begin
        @(posedge sys_clk);
        #1;
      end
      `SFPS_CHK("in_data", w0 + 8'(i), in_data);
      `SFPS_CHK("in_sel", s, in_sel);
      `SFPS_CHK("in_last", i == n - 1, in_last);
      @(posedge sys_clk);
    end
    in_ready <= 1'h0;
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_read();
    fill(1'h0, 8'h50, 6);
    m.sel(2'h0);
    lk(3);
    `SFPS_CHK("empty_n fifo0", 1'h1, empty_n);
    m.desel();
    m.oe(1'h1);
    m.rd(1);
    lk(2);
    `SFPS_CHK("oe without select", 1'h0, data_oe);
    m.sel(2'h0);
    lk(3);
    `SFPS_CHK("drive enabled", 1'h1, data_oe);
    `SFPS_CHK("prefetched word", 8'h50, data_o);
    m.rd(1);
    lk(2);
    `SFPS_CHK("single read", 8'h51, data_o);
    m.oe(1'h0);
    m.rd(1);
    lk(2);
    `SFPS_CHK("undriven", 1'h0, data_oe);
    m.oe(1'h1);
    m.rd(3);
    lk(2);
    `SFPS_CHK("burst read", 8'h55, data_o);
    m.rd(1);
    lk(3);
    `SFPS_CHK("empty after reads", 1'h0, empty_n);
    m.oe(1'h0);
    m.desel();
    $display("Test clocked read done");
  endtask
  task automatic t_write();
    m.sel(2'h2);
    m.wr(8'h10, 3, 1'h0);
    lk(2);
    `SFPS_CHK("empty_n after write", 1'h1, empty_n);
    m.sel(2'h3);
    lk(2);
    `SFPS_CHK("empty_n other fifo", 1'h0, empty_n);
    m.sel(2'h2);
    m.wr(8'h13, 1, 1'h1);
    drain(2'h2, 8'h10, 4);
    $display("Test clocked write done");
  endtask
  task automatic t_full();
    m.sel(2'h3);
    m.wr(8'h30, 17, 1'h0);
    lk(2);
    `SFPS_CHK("full_n", 1'h0, full_n);
    m.idle(1);
    m.commit();
    drain(2'h3, 8'h30, 16);
    // Commit with nothing pending must send no packet
    m.commit();
    lk(6);
    `SFPS_CHK("full_n drained", 1'h1, full_n);
    `SFPS_CHK("word past full", 1'h0, in_valid);
    $display("Test full fifo done");
  endtask
  task automatic t_auto();
    @(posedge sys_clk);
    auto_mode <= 1'h1;
    auto_len <= 5'h04;
    lk(4);
    m.sel(2'h2);
    m.wr(8'h70, 4, 1'h0);
    m.idle(1);
    m.wr(8'h74, 1, 1'h1);
    drain(2'h2, 8'h70, 4);
    drain(2'h2, 8'h74, 1);
    @(posedge sys_clk);
    auto_mode <= 1'h0;
    $display("Test auto commit done");
  endtask
  task automatic t_async();
    @(posedge sys_clk);
    async_mode <= 1'h1;
    lk(4);
    fill(1'h1, 8'hA0, 2);
    m.sel(2'h1);
    m.apulse(0, 8'h00);
    lk(1);
    `SFPS_CHK("strobe read", 8'hA0, data_o);
    m.oe(1'h1);
    // Enable passes three flops and the output register
    lk(4);
    `SFPS_CHK("enable alone drives", 1'h1, data_oe);
    `SFPS_CHK("old word kept", 8'hA0, data_o);
    m.oe(1'h0);
    m.apulse(0, 8'h00);
    lk(1);
    `SFPS_CHK("second strobe read", 8'hA1, data_o);
    m.sel(2'h2);
    m.apulse(1, 8'hB0);
    m.apulse(1, 8'hB1);
    m.apulse(2, 8'h00);
    drain(2'h2, 8'hB0, 2);
    $display("Test strobe mode done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    arst_n = 1'h0;
    async_mode = 1'h0;
    auto_mode = 1'h0;
    auto_len = 5'h00;
    in_ready = 1'h0;
    fill_valid = 1'h0;
    fill_sel = 1'h0;
    fill_data = 8'h00;
    repeat (12) @(posedge sys_clk);
    repeat (3) @(posedge link_clk);
    #1;
    `SFPS_CHK("reset outputs", {data_oe, full_n, empty_n, in_valid,
              fill_ready}, 5'h09);
    @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (6) @(posedge link_clk);
    t_read();
    t_write();
    t_full();
    t_auto();
    t_async();
    close_out();
  end
  // The tests need well under 1500 link cycles
  initial begin
    repeat (3000) @(posedge link_clk);
    mismatches++;
    close_out();
  end
endmodule
